// *** hw/dacm_ctrl.v ***
// Encode timing, nap, stabilizer lock and output format control
`include "dacm_consts.vh"
`timescale 1ns/1ns
module dacm_ctrl #(
   parameter WORD_W = `DACM_WORD_W,
   parameter CLK_HZ = `DACM_CLK_HZ,
   parameter NAP_HZ = `DACM_NAP_HZ,
   parameter LOCK_CYCLES = `DACM_LOCK_CYCLES
) (
   input wire clk,
   input wire reset,
   input wire encode_pos_in,
   input wire encode_neg_in,
   input wire program_style_select,
   input wire cs_n,
   input wire sck,
   input wire sdi,
   input wire [WORD_W-1:0] chan_one_sample,
   input wire [WORD_W-1:0] chan_two_sample,
   input wire chan_one_over,
   input wire chan_two_over,
   output reg [WORD_W-1:0] chan_one_word_bus,
   output reg [WORD_W-1:0] chan_two_word_bus,
   output reg chan_one_range_flag,
   output reg chan_two_range_flag,
   output reg sample_clock_out_pos,
   output reg sample_clock_out_neg,
   output reg [1:0] output_format,
   output reg single_ended_encode,
   output reg nap,
   output reg stabilizer_on,
   output reg stabilizer_locked,
   output reg sample_valid,
   output reg sample_strobe
);
   // Longest encode period before nap, rounded down, at least one cycle
   localparam integer NAP_CYCLES = (CLK_HZ / NAP_HZ) < 1 ? 1 : (CLK_HZ / NAP_HZ);
   localparam [1:0] ST_NAP = 2'h0;
   localparam [1:0] ST_LOCK = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   wire enc_p_s, enc_n_s, style_s, cs_s, sck_s, sdi_s;
   dacm_sync u_sync_ep (.clk(clk), .reset(reset), .din(encode_pos_in), .dout(enc_p_s));
   dacm_sync u_sync_en (.clk(clk), .reset(reset), .din(encode_neg_in), .dout(enc_n_s));
   dacm_sync u_sync_st (.clk(clk), .reset(reset), .din(program_style_select), .dout(style_s));
   dacm_sync u_sync_cs (.clk(clk), .reset(reset), .din(cs_n), .dout(cs_s));
   dacm_sync u_sync_ck (.clk(clk), .reset(reset), .din(sck), .dout(sck_s));
   dacm_sync u_sync_di (.clk(clk), .reset(reset), .din(sdi), .dout(sdi_s));

   reg enc_p_d, sck_d;
   reg [15:0] neg_low_cnt;
   reg se_mode;
   reg [1:0] state;
   reg [15:0] period_cnt;
   reg [15:0] last_period;
   reg [7:0] lock_cnt;
   reg phase;
   reg [WORD_W-1:0] hold_one, hold_two;
   reg hold_of1, hold_of2;
   reg [WORD_W-1:0] next_one, next_two;
   reg next_of1;
   reg [1:0] next_format;
   reg next_stab;
   wire [`DACM_MODE_REG_W-1:0] cpm_reg, ofm_reg;

   wire sck_rise = sck_s & ~sck_d;
   // Serial style when style select is low
   dacm_spi u_spi (
      .clk(clk),
      .reset(reset),
      .enable(~style_s),
      .sck_rise(sck_rise),
      .cs_n(cs_s),
      .sdi(sdi_s),
      .clock_phase_mode_reg(cpm_reg),
      .output_format_mode_reg(ofm_reg)
   );

   // Edge history for encode and serial clock
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         enc_p_d <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         enc_p_d <= enc_p_s;
         sck_d <= sck_s;
      end
   end

   // Complement low for a whole nap window is taken as grounded
   // A differential clock never idles low that long, so its halves cannot flip the mode
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         neg_low_cnt <= 16'h0000;
         se_mode <= 1'b0;
      end else if (enc_n_s) begin
         neg_low_cnt <= 16'h0000;
         se_mode <= 1'b0;
      end else if (neg_low_cnt >= NAP_CYCLES[15:0]) begin
         se_mode <= 1'b1;
      end else begin
         neg_low_cnt <= neg_low_cnt + 16'h0001;
      end
   end

   // Positive rise starts conversion; equals complement fall when differential
   wire enc_edge = enc_p_s & ~enc_p_d;

   // Period moved beyond tolerance counts as a frequency change
   wire period_moved = (period_cnt > last_period + `DACM_PERIOD_TOL) ||
      (period_cnt + `DACM_PERIOD_TOL < last_period);

   // Configuration source by programming style
   always @* begin
      if (style_s) begin
         next_stab = ~cs_s;
         // Strap picks full rate or DDR differential only
         next_format = sck_s ? `DACM_FMT_DDR_DIFF : `DACM_FMT_FULL;
      end else begin
         next_stab = cpm_reg[`DACM_CPM_STAB_BIT];
         next_format = ofm_reg[`DACM_OFM_FMT_MSB:`DACM_OFM_FMT_LSB];
         if (next_format == `DACM_FMT_RSVD)
            next_format = `DACM_FMT_FULL;
      end
   end

   // Encode period watch, nap and stabilizer lock sequence
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_NAP;
         period_cnt <= 16'h0000;
         last_period <= 16'h0000;
         lock_cnt <= 8'h00;
      end else begin
         if (enc_edge) begin
            period_cnt <= 16'h0000;
            last_period <= period_cnt;
         end else if (period_cnt != 16'hffff) begin
            period_cnt <= period_cnt + 16'h0001;
         end
         case (state)
            ST_NAP: begin
               lock_cnt <= 8'h00;
               if (enc_edge)
                  state <= ST_LOCK;
            end
            ST_LOCK: begin
               if (period_cnt >= NAP_CYCLES[15:0]) begin
                  state <= ST_NAP;
               end else if (!stabilizer_on) begin
                  state <= ST_RUN;
               end else if (enc_edge) begin
                  // Restart if the period moved beyond tolerance
                  if (period_moved)
                     lock_cnt <= 8'h00;
                  else if (lock_cnt == LOCK_CYCLES[7:0] - 8'h01)
                     state <= ST_RUN;
                  else
                     lock_cnt <= lock_cnt + 8'h01;
               end
            end
            ST_RUN: begin
               if (period_cnt >= NAP_CYCLES[15:0]) begin
                  state <= ST_NAP;
               end else if (next_stab && !stabilizer_on) begin
                  // Enabling the stabilizer starts a fresh lock
                  lock_cnt <= 8'h00;
                  state <= ST_LOCK;
               end else if (stabilizer_on && enc_edge && period_moved) begin
                  lock_cnt <= 8'h00;
                  state <= ST_LOCK;
               end
            end
            default: state <= ST_NAP;
         endcase
      end
   end

   // Capture both channels on the shared encode edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         hold_one <= 12'h000;
         hold_two <= 12'h000;
         hold_of1 <= 1'b0;
         hold_of2 <= 1'b0;
      end else if (enc_edge) begin
         hold_one <= chan_one_sample;
         hold_two <= chan_two_sample;
         hold_of1 <= chan_one_over;
         hold_of2 <= chan_two_over;
      end
   end

   // Regenerated output clock phase: low half after edge, high at mid-period with the stabilizer on, else at the encode fall
   wire half_point = stabilizer_on ? (period_cnt == {1'b0, last_period[15:1]}) : (enc_p_d & ~enc_p_s);
   always @(posedge clk or posedge reset) begin
      if (reset)
         phase <= 1'b0;
      else if (enc_edge)
         phase <= 1'b0;
      else if (half_point)
         phase <= 1'b1;
   end

   // Output lane mapping per format; DDR puts even bits low, odd bits high
   integer i;
   always @* begin
      next_one = hold_one;
      next_two = hold_two;
      next_of1 = hold_of2; // Channel two flag in full rate
      if (output_format != `DACM_FMT_FULL) begin
         next_one = {WORD_W{1'b0}};
         next_two = {WORD_W{1'b0}};
         for (i = 0; i < WORD_W / 2; i = i + 1) begin
            next_one[2*i+1] = phase ? hold_one[2*i+1] : hold_one[2*i];
            next_two[2*i+1] = phase ? hold_two[2*i+1] : hold_two[2*i];
         end
         // Shared flag: channel 2 low, channel 1 high
         next_of1 = phase ? hold_of1 : hold_of2;
      end
   end

   // Registered outputs
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         chan_one_word_bus <= 12'h000;
         chan_two_word_bus <= 12'h000;
         chan_one_range_flag <= 1'b0;
         chan_two_range_flag <= 1'b0;
         sample_clock_out_pos <= 1'b0;
         sample_clock_out_neg <= 1'b1;
         output_format <= `DACM_FMT_FULL;
         single_ended_encode <= 1'b0;
         nap <= 1'b1;
         stabilizer_on <= 1'b0;
         stabilizer_locked <= 1'b0;
         sample_valid <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         chan_one_word_bus <= next_one;
         chan_two_word_bus <= next_two;
         chan_one_range_flag <= (output_format == `DACM_FMT_FULL) ? hold_of1 : 1'b0;
         chan_two_range_flag <= next_of1;
         sample_clock_out_pos <= phase & (state != ST_NAP);
         sample_clock_out_neg <= ~(phase & (state != ST_NAP));
         output_format <= next_format;
         single_ended_encode <= se_mode;
         nap <= (state == ST_NAP);
         stabilizer_on <= next_stab;
         stabilizer_locked <= (state == ST_RUN) & stabilizer_on;
         sample_valid <= (state == ST_RUN);
         sample_strobe <= enc_edge & (state == ST_RUN);
      end
   end
endmodule // dacm_ctrl

// *** common/dacm_consts.vh ***
// Constants shared by the encode and output-mode control design
`ifndef DACM_CONSTS_VH
`define DACM_CONSTS_VH
`define DACM_WORD_W 12
`define DACM_NAP_HZ 500000
`define DACM_CLK_HZ 125000000
`define DACM_LOCK_CYCLES 100
`define DACM_PERIOD_TOL 16'h0002
`define DACM_FMT_FULL 2'h0
`define DACM_FMT_DDR_SE 2'h1
`define DACM_FMT_DDR_DIFF 2'h2
`define DACM_FMT_RSVD 2'h3
`define DACM_CPM_STAB_BIT 0
`define DACM_OFM_FMT_LSB 0
`define DACM_OFM_FMT_MSB 1
`define DACM_MODE_REG_W 8
`define DACM_ADDR_CPM 7'h02
`define DACM_ADDR_OFM 7'h03
`define DACM_SPI_FRAME 16
`define DACM_CPM_RESET 8'h00
`define DACM_OFM_RESET 8'h00
`endif

// *** hw/dacm_sync.v ***
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
module dacm_sync (
   input wire clk,
   input wire reset,
   input wire din,
   output reg dout
);
   reg stage;
   // First stage read only by the second
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         stage <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage <= din;
         dout <= stage;
      end
   end
endmodule // dacm_sync

// *** hw/dacm_spi.v ***
// Serial mode register port, write only
`include "dacm_consts.vh"
`timescale 1ns/1ns
module dacm_spi (
   input wire clk,
   input wire reset,
   input wire enable,
   input wire sck_rise,
   input wire cs_n,
   input wire sdi,
   output reg [`DACM_MODE_REG_W-1:0] clock_phase_mode_reg,
   output reg [`DACM_MODE_REG_W-1:0] output_format_mode_reg
);
   reg [`DACM_SPI_FRAME-1:0] shift;
   reg [4:0] count;
   wire [`DACM_SPI_FRAME-1:0] next_shift = {shift[`DACM_SPI_FRAME-2:0], sdi};
   // Shift on rising serial clock while selected, commit on sixteenth bit
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         shift <= 16'h0000;
         count <= 5'h00;
         clock_phase_mode_reg <= `DACM_CPM_RESET;
         output_format_mode_reg <= `DACM_OFM_RESET;
      end else if (!enable || cs_n) begin
         count <= 5'h00;
      end else if (sck_rise) begin
         shift <= next_shift;
         if (count == 5'h0f) begin
            count <= 5'h00;
            // Bit 15 low is a write, bits 14:8 address, 7:0 data
            if (!next_shift[15] && next_shift[14:8] == `DACM_ADDR_CPM)
               clock_phase_mode_reg <= next_shift[7:0];
            if (!next_shift[15] && next_shift[14:8] == `DACM_ADDR_OFM)
               output_format_mode_reg <= next_shift[7:0];
         end else begin
            count <= count + 5'h01;
         end
      end
   end
endmodule // dacm_spi

// *** sim/dacm_rx_model.sv ***
// Receiver model capturing sample words
`timescale 1ns/1ns
module dacm_rx_model (
   input wire clk,
   input wire reset,
   input wire [11:0] chan_one_word_bus,
   input wire [11:0] chan_two_word_bus,
   input wire sample_strobe,
   input wire sample_valid,
   output reg [11:0] last_one,
   output reg [11:0] last_two,
   output reg [7:0] word_cnt
);
   reg take;
   // Words settle one cycle after the strobe
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         take <= 1'b0;
         last_one <= 12'h000;
         last_two <= 12'h000;
         word_cnt <= 8'h00;
      end else begin
         take <= sample_strobe && sample_valid;
         if (take) begin
            last_one <= chan_one_word_bus;
            last_two <= chan_two_word_bus;
            word_cnt <= word_cnt + 8'h01;
         end
      end
   end
endmodule // dacm_rx_model

// *** sim/dacm_ctrl_props.sv ***
// Checker for encode, nap and output mode control
`include "dacm_consts.vh"
`timescale 1ns/1ns
module dacm_ctrl_props (
   input wire clk,
   input wire reset,
   input wire encode_pos_in,
   input wire encode_neg_in,
   input wire program_style_select,
   input wire cs_n,
   input wire sck,
   input wire [`DACM_WORD_W-1:0] chan_one_word_bus,
   input wire chan_one_range_flag,
   input wire sample_clock_out_pos,
   input wire sample_clock_out_neg,
   input wire [1:0] output_format,
   input wire single_ended_encode,
   input wire nap,
   input wire stabilizer_on,
   input wire sample_valid,
   input wire sample_strobe
);
   reg [8:0] pos_still;
   reg [8:0] neg_low;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Quiet time of the encode pin and grounded time of its complement
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pos_still <= 9'h000;
         neg_low <= 9'h000;
      end else begin
         pos_still <= ($past(encode_pos_in) != encode_pos_in) ? 9'h000 : pos_still + {8'h00, ~&pos_still};
         neg_low <= encode_neg_in ? 9'h000 : neg_low + {8'h00, ~&neg_low};
      end
   end
   sequence rise_live;
      $rose(encode_pos_in) && sample_valid && !nap;
   endsequence
   sequence fmt_held;
      (program_style_select && $stable(sck)) [*8];
   endsequence
   sequence stab_held;
      (program_style_select && $stable(cs_n)) [*8];
   endsequence
   clk_pair_a: assert property (sample_clock_out_pos != sample_clock_out_neg) else $error("clock pair equal");
   nap_stop_a: assert property (pos_still >= 9'h104 |-> nap) else $error("no nap on stopped encode");
   se_detect_a: assert property (neg_low >= 9'h12c |-> single_ended_encode) else $error("single-ended missed");
   strobe_pulse_a: assert property (sample_strobe |=> !sample_strobe) else $error("strobe too long");
   strobe_valid_a: assert property (sample_strobe |-> sample_valid) else $error("strobe while invalid");
   rise_strobe_a: assert property (rise_live |-> ##[2:6] (sample_strobe || !sample_valid)) else $error("rise lost");
   fmt_strap_a: assert property (fmt_held |-> output_format == (sck ? `DACM_FMT_DDR_DIFF : `DACM_FMT_FULL))
      else $error("strap format wrong");
   stab_strap_a: assert property (stab_held |-> stabilizer_on == !cs_n) else $error("strap stabilizer wrong");
   ddr_even_a: assert property ((output_format != `DACM_FMT_FULL) [*4] |-> !chan_one_word_bus[0] && !chan_one_range_flag)
      else $error("double rate unused pins set");
endmodule // dacm_ctrl_props
bind dacm_ctrl dacm_ctrl_props u_props (.clk(clk), .reset(reset), .encode_pos_in(encode_pos_in),
   .encode_neg_in(encode_neg_in), .program_style_select(program_style_select), .cs_n(cs_n), .sck(sck),
   .chan_one_word_bus(chan_one_word_bus), .chan_one_range_flag(chan_one_range_flag),
   .sample_clock_out_pos(sample_clock_out_pos), .sample_clock_out_neg(sample_clock_out_neg),
   .output_format(output_format), .single_ended_encode(single_ended_encode), .nap(nap),
   .stabilizer_on(stabilizer_on), .sample_valid(sample_valid), .sample_strobe(sample_strobe));

// *** sim/tb_top.sv ***
// Testbench for encode and output mode control
`include "dacm_consts.vh"
`timescale 1ns/1ns
module tb_top;
   logic clk, reset, enc_p, enc_n, style, cs_n, sck, sdi, ov1, ov2, run, diff;
   logic [11:0] s1, s2, b1, b2, l1, l2;
   logic f1, f2, cp, cn, se, nap, son, slk, sv, stb;
   logic [1:0] fmt;
   logic [7:0] cnt;
   integer error_cnt, samples_checked, k, n;
   dacm_ctrl #(.LOCK_CYCLES(4)) dut (.clk(clk), .reset(reset), .encode_pos_in(enc_p), .encode_neg_in(enc_n),
      .program_style_select(style), .cs_n(cs_n), .sck(sck), .sdi(sdi), .chan_one_sample(s1),
      .chan_two_sample(s2), .chan_one_over(ov1), .chan_two_over(ov2), .chan_one_word_bus(b1),
      .chan_two_word_bus(b2), .chan_one_range_flag(f1), .chan_two_range_flag(f2), .sample_clock_out_pos(cp),
      .sample_clock_out_neg(cn), .output_format(fmt), .single_ended_encode(se), .nap(nap),
      .stabilizer_on(son), .stabilizer_locked(slk), .sample_valid(sv), .sample_strobe(stb));
   dacm_rx_model rx (.clk(clk), .reset(reset), .chan_one_word_bus(b1), .chan_two_word_bus(b2),
      .sample_strobe(stb), .sample_valid(sv), .last_one(l1), .last_two(l2), .word_cnt(cnt));
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Encode pin, 80 ns period, on rising clock edges
   initial begin
      #4;
      forever begin
         #40;
         if (run) enc_p = ~enc_p;
         if (diff) enc_n = ~enc_p;
      end
   end
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task cycles(input integer c);
      repeat (c) @(negedge clk);
   endtask
   // Serial frame, MSB first, sck well below clk/6
   task spi_write(input logic [15:0] frame);
      integer i;
      begin
         cs_n = 1'b0;
         for (i = 15; i >= 0; i = i - 1) begin
            sdi = frame[i];
            cycles(4);
            sck = 1'b1;
            cycles(4);
            sck = 1'b0;
         end
         cycles(4);
         cs_n = 1'b1;
         cycles(8);
      end
   endtask
   task final_report;
      begin
         $display("Checks %0d errors %0d", samples_checked, error_cnt);
         if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Watchdog
   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      final_report;
   end
   // Main sequence
   initial begin
      {reset, run} = 2'b11;
      {enc_p, enc_n, style, sck, sdi, ov1, ov2, diff} = 8'h00;
      {cs_n, s1, s2} = {1'b1, 24'h000000};
      {error_cnt, samples_checked} = 0;
      cycles(15);
      check("nap", nap, 1);
      check("clk_neg", cn, 1);
      check("format", fmt, `DACM_FMT_FULL);
      cycles(1);
      reset = 1'b0;
      spi_write({1'b0, `DACM_ADDR_CPM, 8'h01}); // Encode at 12.5 Msps
      check("stab_on", son, 1);
      check("locked", slk, 0);
      check("valid", sv, 0);
      for (k = 0; k < 600 && sv !== 1'b1; k = k + 1) cycles(1);
      check("valid", sv, 1);
      check("locked", slk, 1);
      cycles(150);
      check("se", se, 1);
      {s1, s2, ov1} = {12'h5a3, 12'ha5c, 1'b1};
      n = cnt;
      for (k = 0; k < 200 && cnt < n + 2; k = k + 1) cycles(1);
      check("word_one", l1, 12'h5a3);
      check("word_two", l2, 12'ha5c);
      check("flags", {f1, f2}, 2'b10);
      for (k = 1; k < 3; k = k + 1) begin
         spi_write({1'b0, `DACM_ADDR_OFM, 6'h00, k[1:0]});
         check("format", fmt, k[1:0]);
         check("even_bit", b1[0], 0);
      end
      spi_write({1'b1, `DACM_ADDR_OFM, 8'h00});
      check("format", fmt, `DACM_FMT_DDR_DIFF);
      spi_write({1'b0, `DACM_ADDR_OFM, 8'h03});
      check("format", fmt, `DACM_FMT_FULL);
      {style, sck} = 2'b11;
      cycles(12);
      check("format", fmt, `DACM_FMT_DDR_DIFF);
      sck = 1'b0;
      cycles(12);
      check("format", fmt, `DACM_FMT_FULL);
      cs_n = 1'b0;
      cycles(12);
      check("stab_on", son, 1);
      cs_n = 1'b1;
      cycles(12);
      check("stab_on", son, 0);
      style = 1'b0;
      run = 1'b0;
      cycles(400);
      check("nap", {nap, cp}, 2'b10);
      run = 1'b1;
      cycles(60);
      check("nap", nap, 0);
      diff = 1'b1;
      cycles(100);
      check("se", se, 0);
      final_report;
   end
endmodule // tb_top
